/* File: verilog/switching_clock_mode_sync.sv */
// Purpose: Mode select and switching clock for a PWM controller
// Assumes: Resistor pin presence arrives as a level from an analog detector
// Notes: Sync pin driven in internal mode, sampled in external mode
// Notes on behaviour
// - Mode follows resistor pin populated or floating plus sync activity.
// - Internal rate set by resistor code, 100 kHz to 2 MHz.
// - No resistor and no sync clock means no switching at all.
// - Internal mode drives sync pin at twice the switching rate.
// - Driven sync clock is in phase with switching cycle.
// - Floating resistor pin makes sync pin a clock input.
// - External clock is inverted internally before use.
// - External mode switches at half sync rate, out of phase.
// - Without running sync input, drive outputs stay inactive.
// - Secondary inverts received clock, lagging primary by 90 or 270 degrees.
`timescale 1ns/1ps
`default_nettype none
module switching_clock_mode_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic freq_set_resistor_pin,
  input wire logic [sw_clk_pkg::HALF_W-1:0] freq_half_code,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic primary_drive_a,
  output logic primary_drive_b,
  output logic switching_active,
  output logic [2:0] freq_mode
);
  import sw_clk_pkg::*;

  logic rt_m_r, rt_s_r, sy_m_r, sy_s_r, sy_d_r;
  logic [HALF_W-1:0] half_r;
  logic [HALF_W-1:0] cnt_r;
  logic osc_r;
  logic [LOSS_W-1:0] loss_r;
  logic ext_run_r;
  freq_mode_e mode_r;
  logic ext_clk;
  logic dbl_d_r;
  logic dbl_rise;
  logic run;
  logic phase_r;

  function automatic logic [HALF_W-1:0] clamp_half(input logic [HALF_W-1:0] c);
    if (c < HALF_W'(HALF_MIN_CYC)) begin
      return HALF_W'(HALF_MIN_CYC);
    end else if (c > HALF_W'(HALF_MAX_CYC)) begin
      return HALF_W'(HALF_MAX_CYC);
    end
    return c;
  endfunction : clamp_half

  // Pin inputs pass two flops; first stage read only by second
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rt_m_r <= 1'b0;
      rt_s_r <= 1'b0;
      sy_m_r <= 1'b0;
      sy_s_r <= 1'b0;
      sy_d_r <= 1'b0;
    end else begin
      rt_m_r <= freq_set_resistor_pin;
      rt_s_r <= rt_m_r;
      sy_m_r <= sync_in;
      sy_s_r <= sy_m_r;
      sy_d_r <= sy_s_r;
    end
  end

  // Activity watchdog: a live sync clock is required before switching
  always_ff @(posedge core_clk) begin
    if (sys_rst || rt_s_r) begin
      loss_r <= '0;
      ext_run_r <= 1'b0;
    end else if (sy_s_r != sy_d_r) begin
      loss_r <= '0;
      ext_run_r <= 1'b1;
    end else if (loss_r == LOSS_W'(LOSS_CYC)) begin
      ext_run_r <= 1'b0;
    end else begin
      loss_r <= loss_r + 1'b1;
    end
  end

  // Mode decode from pin configuration
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r <= MODE_OFF;
    end else if (rt_s_r) begin
      mode_r <= MODE_INT;
    end else if (ext_run_r) begin
      mode_r <= MODE_EXT;
    end else begin
      mode_r <= MODE_OFF;
    end
  end

  // Internal oscillator at double rate; half period from resistor code
  always_ff @(posedge core_clk) begin
    if (sys_rst || mode_r != MODE_INT) begin
      half_r <= HALF_RST;
      cnt_r <= '0;
      osc_r <= 1'b0;
    end else if (cnt_r + 1'b1 >= half_r) begin
      half_r <= clamp_half(freq_half_code);
      cnt_r <= '0;
      osc_r <= ~osc_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // External clock inverted; secondary phase depends on lock instant
  assign ext_clk = ~sy_s_r;
  assign run = (mode_r != MODE_OFF);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dbl_d_r <= 1'b0;
    end else begin
      dbl_d_r <= (mode_r == MODE_INT) ? osc_r : ext_clk;
    end
  end
  assign dbl_rise = ((mode_r == MODE_INT) ? osc_r : ext_clk) & ~dbl_d_r;

  toggle_div u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(run),
    .rise_pulse(dbl_rise),
    .phase_r(phase_r)
  );

  // Outputs from flops; sync driven only in internal mode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
      primary_drive_a <= 1'b0;
      primary_drive_b <= 1'b0;
      switching_active <= 1'b0;
      freq_mode <= MODE_OFF;
    end else begin
      sync_out <= (mode_r == MODE_INT) & osc_r;
      sync_oe <= (mode_r == MODE_INT);
      primary_drive_a <= run & phase_r;
      primary_drive_b <= run & ~phase_r & dbl_d_r;
      switching_active <= run;
      freq_mode <= mode_r;
    end
  end

  // Assertions; steady modes keep mode entry from tripping the checks
  sequence s_int_steady;
    (mode_r == MODE_INT) ##1 (mode_r == MODE_INT);
  endsequence

  sequence s_ext_steady;
    (mode_r == MODE_EXT) ##1 (mode_r == MODE_EXT);
  endsequence

  sequence s_sync_rise;
    s_int_steady ##0 $rose(sync_out);
  endsequence

  a_off_no_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_OFF) |=> !primary_drive_a)
    else $error("drive active with no clock source");
  a_int_drives_sync: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_INT) |=> sync_oe)
    else $error("sync not driven in internal mode");
  a_ext_releases_sync: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_EXT) |=> !sync_oe)
    else $error("sync driven in external mode");
  a_mode_from_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
    rt_s_r |=> (mode_r == MODE_INT))
    else $error("populated pin did not select internal mode");
  a_ext_invert: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_ext_steady ##0 $fell(sy_s_r) |=> $changed(phase_r))
    else $error("external clock not inverted");
  a_toggle_half: assert property (@(posedge core_clk) disable iff (sys_rst)
    (run && dbl_rise && $past(run)) |=> (phase_r != $past(phase_r)))
    else $error("divider did not toggle");
  a_half_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
    (run && !dbl_rise && $past(run)) |=> $stable(phase_r))
    else $error("divider moved without double rate edge");
  a_sync_in_phase: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_sync_rise |=> $changed(primary_drive_a))
    else $error("sync out of phase");
  a_loss_stops: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!rt_s_r && loss_r == LOSS_W'(LOSS_CYC) && !(sy_s_r != sy_d_r)) |=> ##1 (mode_r != MODE_EXT))
    else $error("switching kept without sync clock");
  a_rate_clamped: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_INT) |-> ((half_r >= HALF_W'(HALF_MIN_CYC)) && (half_r <= HALF_W'(HALF_MAX_CYC))))
    else $error("internal rate out of range");

  a_rst_drive_low: assert property (@(posedge core_clk)
    sys_rst |=> ((freq_mode == MODE_OFF) && !primary_drive_a && !primary_drive_b))
    else $error("drive not quiet after reset");

  a_rst_sync_quiet: assert property (@(posedge core_clk)
    sys_rst |=> (!sync_oe && !sync_out && !switching_active))
    else $error("sync pin not quiet after reset");

  a_mode_onehot: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot(mode_r))
    else $error("mode not one-hot");

  a_mode_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> (freq_mode == $past(mode_r)))
    else $error("mode output lags wrongly");

  a_active_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> (switching_active == $past(run)))
    else $error("active flag wrong");

  a_oe_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> (sync_oe == ($past(mode_r) == MODE_INT)))
    else $error("sync enable wrong");

  a_sync_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r != MODE_INT) |=> !sync_out)
    else $error("sync driven outside internal mode");

  a_off_no_drive_b: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_OFF) |=> !primary_drive_b)
    else $error("second drive active with no clock source");

  a_ext_needs_clock: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_EXT) |-> $past(ext_run_r))
    else $error("external mode without live sync");

  a_float_not_int: assert property (@(posedge core_clk) disable iff (sys_rst)
    !rt_s_r |=> (mode_r != MODE_INT))
    else $error("floating pin kept internal mode");

  a_cnt_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_INT) |-> (cnt_r < half_r))
    else $error("oscillator count overran");

  a_osc_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_int_steady ##0 (cnt_r != '0) |-> $stable(osc_r))
    else $error("oscillator moved mid half period");

  a_half_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_int_steady ##0 (cnt_r != '0) |-> $stable(half_r))
    else $error("half period changed mid period");

  a_osc_toggle: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_int_steady ##0 ((cnt_r == '0) && ($past(cnt_r) != '0)) |-> $changed(osc_r))
    else $error("oscillator missed its toggle");

  a_osc_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r != MODE_INT) |=> (!osc_r && (cnt_r == '0)))
    else $error("oscillator running outside internal mode");

  a_phase_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    !run |=> !phase_r)
    else $error("divider running while stopped");

  a_drive_excl: assert property (@(posedge core_clk) disable iff (sys_rst)
    primary_drive_b |-> !primary_drive_a)
    else $error("both drives high");

  a_sync_follows_osc: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_r == MODE_INT) |=> (sync_out == $past(osc_r)))
    else $error("sync out not from oscillator");

  a_loss_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
    loss_r <= LOSS_W'(LOSS_CYC))
    else $error("loss counter overran");

  a_edge_restarts: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!rt_s_r && (sy_s_r != sy_d_r)) |=> ((loss_r == '0) && ext_run_r))
    else $error("sync edge did not restart watchdog");

  a_int_clears_watch: assert property (@(posedge core_clk) disable iff (sys_rst)
    rt_s_r |=> (!ext_run_r && (loss_r == '0)))
    else $error("watchdog live in internal mode");

  a_ext_fall_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_ext_steady ##0 $fell(sy_s_r) |-> dbl_rise)
    else $error("sync fall gave no edge pulse");

  a_ext_rise_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_ext_steady ##0 $rose(sy_s_r) |-> !dbl_rise)
    else $error("sync rise gave an edge pulse");

  a_drive_needs_run: assert property (@(posedge core_clk) disable iff (sys_rst)
    primary_drive_a |-> $past(run))
    else $error("drive high while stopped");

  a_drive_b_needs_run: assert property (@(posedge core_clk) disable iff (sys_rst)
    primary_drive_b |-> $past(run))
    else $error("second drive high while stopped");

  a_sync_only_int: assert property (@(posedge core_clk) disable iff (sys_rst)
    sync_out |-> sync_oe)
    else $error("sync toggles while released");
endmodule : switching_clock_mode_sync
`default_nettype wire

/* File: verilog/sw_clk_pkg.sv */
// Purpose: Shared constants for the switching clock mode and sync block
// Assumes: 40 MHz core clock
// Notes: Frequencies in kHz, times in core cycles
package sw_clk_pkg;
  localparam int unsigned CORE_CLK_KHZ = 40000;
  localparam int unsigned FSW_MIN_KHZ = 100;
  localparam int unsigned FSW_MAX_KHZ = 2000;
  localparam int unsigned SYNC_MIN_KHZ = 200;
  localparam int unsigned SYNC_MAX_KHZ = 4000;
  // Half period of the double-rate clock, in core cycles
  localparam int unsigned HALF_MAX_CYC = CORE_CLK_KHZ / (2 * SYNC_MIN_KHZ);
  localparam int unsigned HALF_MIN_CYC = CORE_CLK_KHZ / (2 * SYNC_MAX_KHZ);
  localparam int unsigned HALF_W = 8;
  localparam logic [HALF_W-1:0] HALF_RST = 8'h32;
  // Sync input counted lost after this many cycles without an edge
  localparam int unsigned LOSS_CYC = 2 * HALF_MAX_CYC + 4;
  localparam int unsigned LOSS_W = 9;
  typedef enum logic [2:0] {
    MODE_OFF = 3'b001,
    MODE_INT = 3'b010,
    MODE_EXT = 3'b100
  } freq_mode_e;
endpackage : sw_clk_pkg

/* File: verilog/toggle_div.sv */
// Purpose: Divide a double-rate clock by two into the switching phase
// Assumes: Edge pulse is one core cycle wide
// Notes: Shared by internal and external sources
`timescale 1ns/1ps
`default_nettype none
module toggle_div (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic rise_pulse,
  output logic phase_r
);
  import sw_clk_pkg::*;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      phase_r <= 1'b0;
    end else if (rise_pulse) begin
      phase_r <= ~phase_r;
    end
  end
endmodule : toggle_div
`default_nettype wire

/* File: verif/sync_source.sv */
// Purpose: External clock source model for the sync pin
// Assumes: Clock stands low while not running
// Notes: Fixed 50 percent duty keeps well inside the allowed window
`timescale 1ns/1ps
`default_nettype none
module sync_source #(
  parameter int HALF_NS = 125
) (
  input wire logic run,
  output logic clk_out
);
  initial clk_out = 1'b0;
  always begin
    wait (run);
    #(HALF_NS) clk_out = ~clk_out;
    if (!run) clk_out = 1'b0;
  end
endmodule : sync_source
`default_nettype wire

/* File: verif/switching_clock_mode_sync_test.sv */
// Purpose: Self-checking bench for mode select and switching clock
// Assumes: Source at 4 MHz, the top of the legal range
// Notes: Drive half periods and full sync periods are measured between edges seen on the core clock
`timescale 1ns/1ps
`default_nettype none
module switching_clock_mode_sync_test;
  import sw_clk_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rt_pin = 1'b0;
  logic [HALF_W-1:0] half_code = 8'h0a;
  logic src_run = 1'b0;
  logic src_clk, sync_out, sync_oe, drv_a, drv_b, sw_act;
  logic [2:0] mode;
  wire pin_level;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int last_a = 0;
  int per_a = 0;
  int last_s = 0;
  int per_s = 0;
  int h;
  logic a_d = 1'b0;
  logic s_d = 1'b0;
  logic a_at_pin = 1'b0;
  logic sec_a, sec_b, sec_out, sec_oe, sec_act;
  logic [2:0] sec_mode;
  logic sec_d = 1'b0;
  logic both_hi = 1'b0;
  logic b_seen = 1'b0;
  int lag_s = 0;
  logic [31:0] rng = 32'd76;
  assign pin_level = sync_oe ? sync_out : src_clk;
  always #12.5 core_clk = ~core_clk;
  sync_source #(.HALF_NS(125)) i_src (.run(src_run), .clk_out(src_clk));
  switching_clock_mode_sync i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .freq_set_resistor_pin(rt_pin),
    .freq_half_code(half_code), .sync_in(pin_level), .sync_out(sync_out), .sync_oe(sync_oe),
    .primary_drive_a(drv_a), .primary_drive_b(drv_b), .switching_active(sw_act), .freq_mode(mode));
  // Second controller on the shared pin with its resistor pin floating
  switching_clock_mode_sync i_sec (.core_clk(core_clk), .sys_rst(sys_rst), .freq_set_resistor_pin(1'b0),
    .freq_half_code(half_code), .sync_in(pin_level), .sync_out(sec_out), .sync_oe(sec_oe),
    .primary_drive_a(sec_a), .primary_drive_b(sec_b), .switching_active(sec_act), .freq_mode(sec_mode));
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    a_d <= drv_a;
    s_d <= sync_out;
    sec_d <= sec_a;
    if (sec_a !== sec_d) begin
      lag_s <= cyc - last_a;
    end
    if (drv_a && drv_b) begin
      both_hi <= 1'b1;
    end
    if (drv_b) begin
      b_seen <= 1'b1;
    end
    if (drv_a !== a_d) begin
      last_a <= cyc;
      per_a <= cyc - last_a;
      a_at_pin <= pin_level;
    end
    if (sync_out && !s_d) begin
      last_s <= cyc;
      per_s <= cyc - last_s;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int clamp_half(input int c);
    return (c < 5) ? 5 : ((c > 100) ? 100 : c);
  endfunction : clamp_half
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cycles
  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    #(25 * 20000);
    check("watchdog", 32'h0, 32'h1);
    test_done();
  end
  initial begin
    cycles(6);
    sys_rst = 1'b0;
    check("mode_reset", 32'(mode), 32'(MODE_OFF));
    cycles(150);
    check("mode_off", 32'(mode), 32'(MODE_OFF));
    check("active_off", 32'(sw_act), 32'h0);
    check("drive_off", 32'(drv_a), 32'h0);
    $display("Test no source done");
    rt_pin = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      // Corners first: both ends of the range, then out of range, then random
      half_code = (i == 0) ? 8'h05 : (i == 1) ? 8'h64 : (i == 2) ? 8'hff : 8'(5 + rng % 96);
      h = clamp_half(int'(half_code));
      // Old half period may still run out before the new one loads
      cycles(12 * h + 240);
      check("mode_int", 32'(mode), 32'(MODE_INT));
      check("sync_oe_int", 32'(sync_oe), 32'h1);
      check("sync_period", 32'(per_s), 32'(2 * h));
      check("drive_half", 32'(per_a), 32'(2 * h));
      check("drive_phase", 32'(a_at_pin), 32'h1);
      check("active_int", 32'(sw_act), 32'h1);
      check("sec_mode", 32'(sec_mode), 32'(MODE_EXT));
      check("sec_oe", 32'(sec_oe), 32'h0);
      check("sec_active", 32'(sec_act), 32'h1);
      check("sec_lag", 32'(lag_s), 32'(h + 3));
    end
    $display("Test internal done");
    rt_pin = 1'b0;
    src_run = 1'b1;
    cycles(200);
    check("mode_ext", 32'(mode), 32'(MODE_EXT));
    check("sync_oe_ext", 32'(sync_oe), 32'h0);
    check("drive_half_ext", 32'(per_a), 32'd10);
    check("drive_inverted", 32'(a_at_pin), 32'h0);
    check("active_ext", 32'(sw_act), 32'h1);
    $display("Test external done");
    src_run = 1'b0;
    cycles(LOSS_CYC + 20);
    check("active_lost", 32'(sw_act), 32'h0);
    check("mode_lost", 32'(mode), 32'(MODE_OFF));
    check("drive_ab_overlap", 32'(both_hi), 32'h0);
    check("drive_b_seen", 32'(b_seen), 32'h1);
    $display("Test loss done");
    test_done();
  end
endmodule : switching_clock_mode_sync_test
`default_nettype wire
